// >>> hw/ihp_host.sv
`timescale 1ns/1ns
`include "ihp_map.svh"
module ihp_host (
	input  wire logic                 ref_clk_i,
	input  wire logic                 sys_rst_i,
	input  wire ihp_pkg::ihp_req_type req_i,
	input  wire logic                 req_valid_i,
	output logic                      req_ready_o,
	output ihp_pkg::ihp_rsp_type      rsp_o,
	output logic                      rsp_valid_o,
	input  wire logic                 rsp_ready_i,
	input  wire logic                 slave_sel_i,
	input  wire logic                 int_en_i,
	output logic                      irq_o,
	output logic      [15:0]          hd_o,
	output logic                      hd_oe_o,
	input  wire logic [15:0]          hd_i,
	output logic      [2:0]           ha_o,
	output logic                      cs0_n_o,
	output logic                      cs1_n_o,
	output logic                      diow_n_o,
	output logic                      dior_n_o,
	output logic                      rst_n_o,
	output logic                      csel_o,
	output logic                      nien_o,
	input  wire logic                 iordy_i,
	input  wire logic                 intrq_i,
	input  wire logic                 intrq_oe_i,
	input  wire logic                 iois16_n_i
);
	ihp_pkg::ihp_state_type state;
	ihp_pkg::ihp_state_type next_state;
	ihp_pkg::ihp_req_type   cur;
	ihp_pkg::ihp_req_type   next_cur;
	logic [3:0]             cnt;
	logic [3:0]             next_cnt;
	logic [7:0]             tmo;
	logic [7:0]             next_tmo;
	logic [15:0]            rdat;
	logic [15:0]            next_rdat;
	logic                   w16;
	logic                   next_w16;
	logic                   tflag;
	logic                   next_tflag;
	logic                   rsp_push;
	logic                   fifo_ready;
	logic [17:0]            fifo_out;
	logic [1:0]             rdy_s;
	logic [1:0]             irq_s;
	logic [1:0]             oe_s;
	logic [31:0]            hd_s;
	logic [1:0]             i16_s;
	logic                   rdy_sync;

	function automatic logic is_data(input ihp_pkg::ihp_req_type r);
		is_data = !r.cs1 && (r.addr == `IHP_DATA_ADDR);
	endfunction : is_data

	// Pin synchronisers
	always_ff @(posedge ref_clk_i) begin
		rdy_s <= {rdy_s[0], iordy_i};
		irq_s <= {irq_s[0], intrq_i};
		oe_s  <= {oe_s[0], intrq_oe_i};
		i16_s <= {i16_s[0], iois16_n_i};
		hd_s  <= {hd_s[15:0], hd_i};
	end
	assign rdy_sync = rdy_s[1];

	always_comb begin
		next_state = state;
		next_cur   = cur;
		next_cnt   = cnt;
		next_tmo   = tmo;
		next_rdat  = rdat;
		next_w16   = w16;
		next_tflag = tflag;
		rsp_push   = 1'b0;
		unique case (state)
			ihp_pkg::ST_IDLE: begin
				if (req_valid_i && fifo_ready) begin
					next_cur   = req_i;
					next_cnt   = `IHP_SETUP_CYC;
					next_tflag = 1'b0;
					next_state = ihp_pkg::ST_SETUP;
				end
			end
			ihp_pkg::ST_SETUP: begin
				next_cnt = cnt - 4'h1;
				if (cnt == 4'h1) begin
					next_cnt   = `IHP_PULSE_CYC;
					next_state = ihp_pkg::ST_PULSE;
				end
			end
			ihp_pkg::ST_PULSE: begin
				next_cnt = cnt - 4'h1;
				if (cnt == 4'h1) begin
					next_tmo   = `IHP_RDY_TMO;
					next_state = ihp_pkg::ST_WAIT;
				end
			end
			ihp_pkg::ST_WAIT: begin
				next_tmo = tmo - 8'h01;
				if (rdy_sync || tmo == 8'h00) begin
					next_tflag = !rdy_sync;
					next_rdat = is_data(cur) ? hd_s[31:16] :
						{8'h00, hd_s[23:16]};
					next_w16   = !i16_s[1];
					next_cnt   = `IHP_RECOV_CYC;
					next_state = ihp_pkg::ST_RECOV;
				end
			end
			ihp_pkg::ST_RECOV: begin
				next_cnt = cnt - 4'h1;
				if (cnt == 4'h1) begin
					rsp_push   = 1'b1;
					next_state = ihp_pkg::ST_IDLE;
				end
			end
			default: next_state = ihp_pkg::ST_IDLE;
		endcase
		if (sys_rst_i) begin
			next_state = ihp_pkg::ST_IDLE;
			next_cnt   = 4'h0;
			next_tmo   = 8'h00;
			next_tflag = 1'b0;
			next_w16   = 1'b0;
			next_rdat  = 16'h0000;
			next_cur   = '0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		state <= next_state;
		cur   <= next_cur;
		cnt   <= next_cnt;
		tmo   <= next_tmo;
		rdat  <= next_rdat;
		w16   <= next_w16;
		tflag <= next_tflag;
	end

	logic strobe;
	logic busy;
	assign strobe = state == ihp_pkg::ST_PULSE || state == ihp_pkg::ST_WAIT;
	assign busy   = state != ihp_pkg::ST_IDLE;

	// Pin drivers
	always_ff @(posedge ref_clk_i) begin
		ha_o     <= busy ? cur.addr : 3'h0;
		cs0_n_o  <= !(busy && !cur.cs1);
		cs1_n_o  <= !(busy && cur.cs1);
		// write strobe, data held past rise
		diow_n_o <= !(strobe && next_state != ihp_pkg::ST_RECOV && cur.write);
		dior_n_o <= !(strobe && next_state != ihp_pkg::ST_RECOV && !cur.write);
		hd_oe_o  <= busy && cur.write;
		hd_o     <= is_data(cur) ? cur.wdata : {8'h00, cur.wdata[7:0]};
		csel_o   <= slave_sel_i;
		nien_o   <= !int_en_i;
		rst_n_o  <= !sys_rst_i;
		irq_o    <= irq_s[1] && oe_s[1] && int_en_i;
		if (sys_rst_i) begin
			ha_o     <= 3'h0;
			cs0_n_o  <= 1'b1;
			cs1_n_o  <= 1'b1;
			diow_n_o <= 1'b1;
			dior_n_o <= 1'b1;
			hd_oe_o  <= 1'b0;
			hd_o     <= 16'h0000;
			csel_o   <= 1'b0;
			nien_o   <= 1'b1;
			irq_o    <= 1'b0;
		end
	end

	assign req_ready_o = (state == ihp_pkg::ST_IDLE) && fifo_ready && !sys_rst_i;

	ihp_fifo #(
		.WIDTH(18),
		.DEPTH(`IHP_FIFO_DEPTH)
	) u_fifo (
		.ref_clk_i  (ref_clk_i),
		.sys_rst_i  (sys_rst_i),
		.in_data_i  ({rdat, w16, tflag}),
		.in_valid_i (rsp_push),
		.in_ready_o (fifo_ready),
		.out_data_o (fifo_out),
		.out_valid_o(rsp_valid_o),
		.out_ready_i(rsp_ready_i)
	);
	assign rsp_o = fifo_out;

	property p_strobe_excl;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		!(!diow_n_o && !dior_n_o);
	endproperty
	a_strobe_excl: assert property (p_strobe_excl)
		else $error("both strobes low");
	property p_sel_during_strobe;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		!dior_n_o |-> (cs0_n_o ^ cs1_n_o);
	endproperty
	a_sel_during_strobe: assert property (p_sel_during_strobe)
		else $error("strobe without one chip select");
	property p_wdata_hold;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		$rose(diow_n_o) |-> hd_oe_o && $stable(hd_o);
	endproperty
	a_wdata_hold: assert property (p_wdata_hold)
		else $error("write data dropped at strobe rise");
	property p_no_rd_drive;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		!dior_n_o |-> !hd_oe_o;
	endproperty
	a_no_rd_drive: assert property (p_no_rd_drive)
		else $error("host drives bus during read");
	property p_wait_bound;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		$rose(state == ihp_pkg::ST_WAIT) |-> ##[1:258] state != ihp_pkg::ST_WAIT;
	endproperty
	a_wait_bound: assert property (p_wait_bound)
		else $error("ready wait unbounded");
	property p_csel;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		##1 csel_o == $past(slave_sel_i);
	endproperty
	a_csel: assert property (p_csel)
		else $error("cable select wrong");
	property p_irq_gate;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		!int_en_i ##1 !int_en_i |-> !irq_o && nien_o;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("irq with interrupts disabled");
	property p_addr_stable;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		!dior_n_o && !$past(dior_n_o) |-> $stable(ha_o);
	endproperty
	a_addr_stable: assert property (p_addr_stable)
		else $error("address moved in strobe");
	c_write: cover property (@(posedge ref_clk_i) $rose(diow_n_o));
	c_read: cover property (@(posedge ref_clk_i) $rose(dior_n_o));
	c_timeout: cover property (@(posedge ref_clk_i) rsp_valid_o && rsp_o.timeout);
endmodule : ihp_host

// >>> hw/ihp_map.svh
// Contract
// - Data bus is 16 lines, line 15 most significant, line 0 least.
// - Register accesses carry their byte on the low eight data lines.
// - Data-port transfers always move one full 16-bit word per strobe.
// - Host presents a 3-bit register address the device decodes.
// - Write strobe low with data valid; device latches on rising edge.
// - Read strobe falls; device drives addressed content in response.
// - Chip selects are active low and pick the register block.
// - Device negates ready to stretch a cycle; host waits for release, here at most 256 cycles, then ends the cycle with a timeout flag.
`ifndef IHP_MAP_SVH
`define IHP_MAP_SVH
`define IHP_DATA_ADDR    3'h0
`define IHP_SETUP_CYC    4'h3
`define IHP_PULSE_CYC    4'h8
`define IHP_RECOV_CYC    4'h3
`define IHP_RDY_TMO      8'hFF
`define IHP_FIFO_DEPTH   16
`endif

// >>> hw/ihp_pkg.sv
package ihp_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_PULSE = 3'b010,
		ST_WAIT  = 3'b011,
		ST_RECOV = 3'b100
	} ihp_state_type;
	typedef struct packed {
		logic        write;
		logic        cs1;
		logic [2:0]  addr;
		logic [15:0] wdata;
	} ihp_req_type;
	typedef struct packed {
		logic [15:0] rdata;
		logic        word16;
		logic        timeout;
	} ihp_rsp_type;
endpackage : ihp_pkg

// >>> hw/ihp_fifo.sv
`timescale 1ns/1ns
module ihp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;
	assign in_ready_o  = (count != DEPTH[AW:0]);
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];
	assign push = in_valid_i && in_ready_o;
	assign pop  = out_valid_o && out_ready_i;
	always_comb begin
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		if (sys_rst_i) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count  = '0;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		wr_ptr <= next_wr_ptr;
		rd_ptr <= next_rd_ptr;
		count  <= next_count;
		if (push)
			mem[wr_ptr] <= in_data_i;
	end
endmodule : ihp_fifo

// >>> sim/ihp_dev_model.sv
`timescale 1ns/1ns
module ihp_dev_model (
	input  wire logic        ref_clk_i,
	input  wire logic [15:0] hd_o_i,
	input  wire logic        hd_oe_i,
	input  wire logic [2:0]  ha_i,
	input  wire logic        cs0_n_i,
	input  wire logic        cs1_n_i,
	input  wire logic        diow_n_i,
	input  wire logic        dior_n_i,
	input  wire logic        nien_i,
	input  wire logic        irq_req_i,
	input  wire logic [15:0] slow_i,
	output logic      [15:0] hd_bus_o,
	output logic             iordy_o,
	output logic             intrq_o,
	output logic             intrq_oe_o,
	output logic             iois16_n_o
);
	logic [15:0] mem [16];
	logic [15:0] last = 16'h0000;
	logic [3:0]  idx;
	logic        sel;
	logic        strb;
	logic        dport;
	int          cnt = 0;
	assign sel = !cs0_n_i || !cs1_n_i;
	assign idx = {cs1_n_i, ha_i};
	assign dport = !cs0_n_i && ha_i == 3'h0;
	assign strb = sel && (!diow_n_i || !dior_n_i);
	always @(posedge ref_clk_i) cnt <= strb ? cnt + 1 : 0;
	assign iordy_o = cnt >= int'(slow_i);
	always @(posedge diow_n_i) begin
		if (sel) mem[idx] <= dport ? hd_o_i : {8'h00, hd_o_i[7:0]};
	end
	always_comb begin
		if (hd_oe_i) hd_bus_o = hd_o_i;
		else if (sel && !dior_n_i && dport) hd_bus_o = mem[idx];
		else if (sel && !dior_n_i) hd_bus_o = {8'hA5, mem[idx][7:0]};
		else hd_bus_o = ~last;
	end
	always @(posedge ref_clk_i) last <= hd_bus_o;
	assign iois16_n_o = !(strb && dport);
	assign intrq_oe_o = !nien_i;
	assign intrq_o = irq_req_i;
endmodule : ihp_dev_model

// >>> sim/test_ihp_host.sv
`timescale 1ns/1ns
module test_ihp_host;
	logic                 ref_clk_i = 0;
	logic                 sys_rst_i = 1;
	logic                 req_valid_i = 0;
	logic                 rsp_ready_i = 0;
	logic                 slave_sel_i = 0;
	logic                 int_en_i = 0;
	logic                 irq_req = 0;
	logic                 drain = 1;
	logic [15:0]          slow = 16'h0000;
	ihp_pkg::ihp_req_type req_i = '0;
	ihp_pkg::ihp_rsp_type rsp_o;
	ihp_pkg::ihp_rsp_type exp_q[$];
	ihp_pkg::ihp_rsp_type msk_q[$];
	logic [15:0]          shadow [16];
	logic [15:0]          hd_o, hd_i;
	logic [2:0]           ha_o;
	logic                 req_ready_o, rsp_valid_o, irq_o, hd_oe_o;
	logic                 cs0_n_o, cs1_n_o, diow_n_o, dior_n_o;
	logic                 csel_o, nien_o, iordy, intrq, intrq_oe, iois16_n;
	logic                 rst_n;
	int                   err_total = 0;
	int                   n_compared = 0;
	int                   cyc = 0;
	ihp_host i_ihp_host (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.req_i(req_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
		.rsp_o(rsp_o), .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i),
		.slave_sel_i(slave_sel_i), .int_en_i(int_en_i), .irq_o(irq_o),
		.hd_o(hd_o), .hd_oe_o(hd_oe_o), .hd_i(hd_i), .ha_o(ha_o),
		.cs0_n_o(cs0_n_o), .cs1_n_o(cs1_n_o), .diow_n_o(diow_n_o),
		.dior_n_o(dior_n_o), .rst_n_o(rst_n), .csel_o(csel_o), .nien_o(nien_o),
		.iordy_i(iordy), .intrq_i(intrq), .intrq_oe_i(intrq_oe),
		.iois16_n_i(iois16_n));
	ihp_dev_model i_ihp_dev_model (.ref_clk_i(ref_clk_i), .hd_o_i(hd_o),
		.hd_oe_i(hd_oe_o), .ha_i(ha_o), .cs0_n_i(cs0_n_o), .cs1_n_i(cs1_n_o),
		.diow_n_i(diow_n_o), .dior_n_i(dior_n_o), .nien_i(nien_o),
		.irq_req_i(irq_req), .slow_i(slow), .hd_bus_o(hd_i),
		.iordy_o(iordy), .intrq_o(intrq), .intrq_oe_o(intrq_oe),
		.iois16_n_o(iois16_n));
	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [17:0] exp_of(logic wr, logic dp, logic to,
		logic [15:0] v);
		if (to) exp_of = 18'h00001;
		else if (wr) exp_of = {16'h0000, dp, 1'b0};
		else exp_of = {dp ? v : {8'h00, v[7:0]}, dp, 1'b0};
	endfunction : exp_of
	function automatic logic [17:0] msk_of(logic wr, logic to);
		msk_of = to ? 18'h00001 : wr ? 18'h00003 : 18'h3FFFF;
	endfunction : msk_of
	task automatic issue(logic wr, logic c1, logic [2:0] a, logic [15:0] d,
		logic to);
		int   i;
		logic dp;
		dp = !c1 && a == 3'h0;
		@(posedge ref_clk_i);
		req_i <= '{wr, c1, a, d};
		req_valid_i <= 1;
		@(posedge ref_clk_i);
		for (i = 0; i < 1000 && !req_ready_o; i++) @(posedge ref_clk_i);
		if (!req_ready_o) err_total++;
		req_valid_i <= 0;
		if (wr) shadow[{c1, a}] = dp ? d : {8'h00, d[7:0]};
		exp_q.push_back(exp_of(wr, dp, to, shadow[{c1, a}]));
		msk_q.push_back(msk_of(wr, to));
	endtask : issue
	task automatic settle();
		int i;
		for (i = 0; i < 900 && exp_q.size() > 0; i++) @(posedge ref_clk_i);
		if (exp_q.size() > 0) err_total++;
	endtask : settle
	always @(posedge ref_clk_i) begin
		rsp_ready_i <= drain && 1'($urandom_range(0, 1));
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			wrap_up();
		end
		if (!sys_rst_i && rsp_valid_o && rsp_ready_i) begin
			if (exp_q.size() == 0) check("extra", 18'h0, 18'h1);
			else check("rsp", rsp_o & msk_q.pop_front(), exp_q.pop_front());
		end
	end
	initial begin
		int i;
		void'($urandom(32'h062D));
		repeat (10) @(posedge ref_clk_i);
		sys_rst_i <= 0;
		@(posedge ref_clk_i);
		for (i = 0; i < 16; i++) issue(1, i[3], i[2:0],
			i == 0 ? 16'h8001 : 16'($urandom()), 0);
		for (i = 15; i >= 0; i--) issue(0, i[3], i[2:0], 16'h0000, 0);
		settle();
		slow <= 16'h0014;
		issue(1, 0, 3'h0, 16'h7FFE, 0);
		issue(0, 0, 3'h0, 16'h0000, 0);
		settle();
		slow <= 16'h012C;
		issue(0, 0, 3'h0, 16'h0000, 1);
		settle();
		slow <= 16'h0000;
		drain <= 0;
		for (i = 0; i < 16; i++) issue(0, 0, 3'h0, 16'h0000, 0);
		repeat (40) @(posedge ref_clk_i);
		check("full", 18'(req_ready_o), 18'h0);
		drain <= 1;
		issue(0, 1, 3'h7, 16'h0000, 0);
		settle();
		check("left", 18'(exp_q.size()), 18'h0);
		slave_sel_i <= 1;
		int_en_i <= 1;
		irq_req <= 1;
		repeat (8) @(posedge ref_clk_i);
		check("csel", 18'(csel_o), 18'h1);
		check("irq", {16'h0, nien_o, irq_o}, 18'h1);
		int_en_i <= 0;
		slave_sel_i <= 0;
		repeat (8) @(posedge ref_clk_i);
		check("csel", 18'(csel_o), 18'h0);
		check("irq", {16'h0, nien_o, irq_o}, 18'h2);
		sys_rst_i <= 1;
		repeat (3) @(posedge ref_clk_i);
		check("rst", {13'h0, rst_n, cs0_n_o, cs1_n_o, dior_n_o, diow_n_o},
			18'h0000F);
		sys_rst_i <= 0;
		issue(0, 0, 3'h0, 16'h0000, 0);
		settle();
		check("left", 18'(exp_q.size()), 18'h0);
		check("rst", 18'(rst_n), 18'h1);
		wrap_up();
	end
endmodule : test_ihp_host
